// ---- hw/sctbm_cfg.svh ----
// offsets, field positions, reset values and counts for the bus monitor register bank
`ifndef SCTBM_CFG_SVH
`define SCTBM_CFG_SVH
// register indices; byte address is four times the index
`define SCTBM_IDX_MODULE_STATUS   7'h50
`define SCTBM_IDX_RSVD_52         7'h52
`define SCTBM_IDX_RSVD_53         7'h53
`define SCTBM_IDX_LINE_MONITOR    7'h54
`define SCTBM_IDX_FIFO_STATUS     7'h55
`define SCTBM_IDX_RSVD_56         7'h56
`define SCTBM_IDX_BUS_DATA_PORT   7'h57
`define SCTBM_IDX_XFER_COUNT      7'h58
`define SCTBM_IDX_RSVD_59         7'h59
`define SCTBM_IDX_RSVD_5A         7'h5a
`define SCTBM_IDX_SYNC_CTL        7'h5b
`define SCTBM_IDX_RSVD_5C         7'h5c
`define SCTBM_IDX_SECOND_CONFIG   7'h61
`define SCTBM_IDX_IRQ_STATUS      7'h70
`define SCTBM_IDX_IRQ_MASK        7'h71
`define SCTBM_IDX_FIFO_READ       7'h72
// field positions
`define SCTBM_BIT_EMPTY           7
`define SCTBM_BIT_FULL            4
`define SCTBM_BIT_CNT_ZERO        2
`define SCTBM_BIT_IN_PROGRESS     0
`define SCTBM_BIT_FAST            7
`define SCTBM_BIT_IRQ_DONE        0
`define SCTBM_BIT_IRQ_FULL        1
// reset values
`define SCTBM_RST_SYNC_CTL        8'h00
`define SCTBM_RST_XFER_COUNT      5'h00
`define SCTBM_RST_DATA_PORT       8'h00
`define SCTBM_RST_IRQ             2'h0
// command codes written to the module status location
`define SCTBM_CMD_ASSERT_DATA     8'h01
`define SCTBM_CMD_DEASSERT_DATA   8'h02
`define SCTBM_CMD_START_XFER      8'h03
`define SCTBM_CMD_STOP_XFER       8'h04
// timing, in controller clock periods
`define SCTBM_BASE_FAST           5'h04
`define SCTBM_BASE_NORMAL         5'h08
// built-in fifo shape
`define SCTBM_FIFO_WIDTH          8
`define SCTBM_FIFO_DEPTH          15
`define SCTBM_FIFO_DEPTH_W        5'h0f
`endif

// ---- hw/sctbm_pkg.sv ----
// types shared by the bus monitor register bank
package sctbm_pkg;
  // request handshake states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_REQ_HI   = 3'b001,
    ST_REQ_LO   = 3'b010,
    ST_WAIT_REL = 3'b011
  } sctbm_state_t;
endpackage : sctbm_pkg

// ---- hw/sctbm_fifo.sv ----
// built-in transfer fifo with fill count and flags
`timescale 1ns/1ns
`include "sctbm_cfg.svh"
module sctbm_fifo (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       pushValid,
  input  wire logic [7:0] pushData,
  output logic            pushReady,
  output logic            popValid,
  input  wire logic       popReady,
  output logic [7:0]      popData,
  output logic [3:0]      fillCount,
  output logic            emptyFlag,
  output logic            fullFlag
);
  logic [7:0] memReg [`SCTBM_FIFO_DEPTH];  // entry storage
  logic [3:0] wrIdxReg;                    // next entry to fill
  logic [3:0] rdIdxReg;                    // oldest entry
  logic [3:0] countReg;                    // occupied entries
  wire        doPush = pushValid && pushReady;
  wire        doPop  = popValid && popReady;
  wire  [3:0] lastIdx = 4'(`SCTBM_FIFO_DEPTH - 1);
  wire  [3:0] wrIdxNext = (wrIdxReg == lastIdx) ? 4'h0 : wrIdxReg + 4'h1;
  wire  [3:0] rdIdxNext = (rdIdxReg == lastIdx) ? 4'h0 : rdIdxReg + 4'h1;

  // flags derive from the single count so they always agree
  assign fillCount = countReg;
  assign emptyFlag = (countReg == 4'h0);
  assign fullFlag  = (countReg == 4'(`SCTBM_FIFO_DEPTH));
  assign pushReady = !fullFlag;
  assign popValid  = !emptyFlag;
  assign popData   = memReg[rdIdxReg];

  // one 8-bit storage register per entry
  genvar e;
  generate
    for (e = 0; e < `SCTBM_FIFO_DEPTH; e++) begin : g_entry
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          memReg[e] <= 8'h00;
        end else if (doPush && wrIdxReg == 4'(e)) begin
          memReg[e] <= pushData;
        end
      end
    end
  endgenerate

  // pointers and count move in the same cycle as push or pop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrIdxReg <= 4'h0;
      rdIdxReg <= 4'h0;
      countReg <= 4'h0;
    end else begin
      if (doPush) wrIdxReg <= wrIdxNext;
      if (doPop) rdIdxReg <= rdIdxNext;
      if (doPush && !doPop) countReg <= countReg + 4'h1;
      else if (doPop && !doPush) countReg <= countReg - 4'h1;
    end
  end
endmodule : sctbm_fifo

// ---- hw/sctbm_regs.sv ----
// bus monitor, data port, byte counter and synchronous timing register bank
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
`include "sctbm_cfg.svh"
module sctbm_regs (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [8:0]  avs_address,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [7:0]  scsiCtlN,
  input  wire logic [7:0]  scsiDataInN,
  output logic [7:0]       scsiDataOutN,
  output logic             scsiDataOeN,
  output logic             reqLineN,
  output logic             irq
);
  // control line positions inside the monitor byte
  localparam int ACK_POS = 1;

  // bus handshake and register state
  logic        waitReg;          // waitrequest flop, low for the answer cycle
  logic [31:0] rdataReg;         // read data held for the answer cycle
  logic [7:0]  syncReg;          // sync_period_offset
  logic        fastReg;          // second_configuration fast_timing_select
  logic [7:0]  dataPortReg;      // bus_data_port written byte
  logic        assertDataReg;    // data lines driven from the data port
  logic [4:0]  byteCountReg;     // cpu_transfer_byte_count
  logic [4:0]  toRequestReg;     // bytes not yet requested
  logic [4:0]  outstandReg;      // requests not yet acknowledged
  logic        xferOnReg;        // transfer in progress
  logic [4:0]  cycCntReg;        // position inside a transfer cycle
  logic        ackPrevReg;       // acknowledge line one cycle ago
  logic [1:0]  irqStatReg;       // sticky events
  logic [1:0]  irqMaskReg;       // event enables
  logic        fullPrevReg;      // fifo full one cycle ago
  logic        irqReg;           // interrupt flop
  logic [7:0]  dataOutReg;       // data pin level
  logic        dataOeReg;        // data pin enable, low drives
  logic        reqReg;           // request pin level
  sctbm_pkg::sctbm_state_t stateReg;
  sctbm_pkg::sctbm_state_t stateNext;

  // fifo hookup
  logic [7:0]  popData;          // oldest fifo byte
  logic [3:0]  fillCount;        // occupied entries
  logic        emptyFlag;        // fifo empty
  logic        fullFlag;         // fifo full
  logic        pushReady;        // room for one more byte
  logic        popValid;         // a byte can be popped

  // address decode and strobes
  wire [6:0]  regIdx     = avs_address[8:2];
  wire        aligned    = (avs_address[1:0] == 2'b00);
  wire        rdStrobe   = avs_read && waitReg;  // first cycle of a read
  wire        wrStrobe   = avs_write && !waitReg && aligned && avs_byteenable[0];  // answer edge
  wire [7:0]  wrByte     = avs_writedata[7:0];
  wire        wrCommand  = wrStrobe && regIdx == `SCTBM_IDX_MODULE_STATUS;
  wire        wrDataPort = wrStrobe && regIdx == `SCTBM_IDX_BUS_DATA_PORT;
  wire        wrCount    = wrStrobe && regIdx == `SCTBM_IDX_XFER_COUNT;
  wire        wrSync     = wrStrobe && regIdx == `SCTBM_IDX_SYNC_CTL;
  wire        wrConfig   = wrStrobe && regIdx == `SCTBM_IDX_SECOND_CONFIG;
  wire        wrIrqStat  = wrStrobe && regIdx == `SCTBM_IDX_IRQ_STATUS;
  wire        wrIrqMask  = wrStrobe && regIdx == `SCTBM_IDX_IRQ_MASK;
  wire        rdFifo     = rdStrobe && aligned && regIdx == `SCTBM_IDX_FIFO_READ && popValid;

  // live line views, pins are negative logic
  wire [7:0]  lineSense  = ~scsiCtlN;
  wire [7:0]  dataSense  = ~scsiDataInN;
  wire        ackSense   = lineSense[ACK_POS];
  wire        ackRise    = ackSense && !ackPrevReg;

  // timing selection
  wire [3:0]  periodField = syncReg[7:4];
  wire [3:0]  offsetField = syncReg[3:0];
  wire        syncMode    = (offsetField != 4'h0);
  wire [4:0]  baseLen     = fastReg ? `SCTBM_BASE_FAST : `SCTBM_BASE_NORMAL;
  wire [4:0]  cycleLen    = baseLen + {1'b0, periodField};
  wire [4:0]  hiLen       = {1'b0, cycleLen[4:1]};
  wire [4:0]  inFlight    = {1'b0, fillCount} + outstandReg;
  wire        roomFree    = (inFlight < `SCTBM_FIFO_DEPTH_W);
  wire        credit      = (outstandReg < {1'b0, offsetField});
  wire        canIssue    = xferOnReg && (toRequestReg != 5'h00) && roomFree && (!syncMode || credit);
  wire        reqIssue    = (stateReg == sctbm_pkg::ST_IDLE) && canIssue;
  wire        pushByte    = xferOnReg && ackRise && (outstandReg != 5'h00);
  wire        xferDone    = xferOnReg && (byteCountReg == 5'h00) && (outstandReg == 5'h00);
  wire        fullRise    = fullFlag && !fullPrevReg;

  // status bytes
  wire [7:0]  fifoStatus   = {emptyFlag, 2'b00, fullFlag, fillCount};
  wire [7:0]  moduleStatus = {5'h00, (byteCountReg == 5'h00), 1'b0, xferOnReg};
  wire [1:0]  irqEvents    = {fullRise, xferDone};
  wire [1:0]  irqStatNext  = irqEvents | (irqStatReg & ~(wrIrqStat ? wrByte[1:0] : 2'b00));

  // read selection; anything not listed reads zero
  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    if (!aligned) begin
      rdByte = 8'h00;
    end else if (regIdx == `SCTBM_IDX_MODULE_STATUS) begin
      rdByte = moduleStatus;
    end else if (regIdx == `SCTBM_IDX_LINE_MONITOR) begin
      rdByte = lineSense;
    end else if (regIdx == `SCTBM_IDX_FIFO_STATUS) begin
      rdByte = fifoStatus;
    end else if (regIdx == `SCTBM_IDX_BUS_DATA_PORT) begin
      rdByte = dataSense;
    end else if (regIdx == `SCTBM_IDX_XFER_COUNT) begin
      rdByte = {3'b000, byteCountReg};
    end else if (regIdx == `SCTBM_IDX_SYNC_CTL) begin
      rdByte = syncReg;
    end else if (regIdx == `SCTBM_IDX_SECOND_CONFIG) begin
      rdByte = {fastReg, 7'h00};
    end else if (regIdx == `SCTBM_IDX_IRQ_STATUS) begin
      rdByte = {6'h00, irqStatReg};
    end else if (regIdx == `SCTBM_IDX_IRQ_MASK) begin
      rdByte = {6'h00, irqMaskReg};
    end else if (regIdx == `SCTBM_IDX_FIFO_READ) begin
      rdByte = popData;
    end
  end

  // request handshake sequencing
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      sctbm_pkg::ST_IDLE: begin
        if (reqIssue) stateNext = sctbm_pkg::ST_REQ_HI;
      end
      sctbm_pkg::ST_REQ_HI: begin
        if (!syncMode) begin
          if (ackSense) stateNext = sctbm_pkg::ST_WAIT_REL;
        end else if (cycCntReg == hiLen - 5'h01) begin
          stateNext = sctbm_pkg::ST_REQ_LO;
        end
      end
      sctbm_pkg::ST_REQ_LO: begin
        // leave one early: the idle cycle before the next start completes the cycle
        if (cycCntReg == cycleLen - 5'h02) stateNext = sctbm_pkg::ST_IDLE;
      end
      sctbm_pkg::ST_WAIT_REL: begin
        if (!ackSense) stateNext = sctbm_pkg::ST_IDLE;
      end
      default: stateNext = sctbm_pkg::ST_IDLE;
    endcase
  end

  // avalon answer: one wait cycle, then the answer edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waitReg  <= 1'b1;
      rdataReg <= 32'h0000_0000;
    end else begin
      waitReg <= !((avs_read || avs_write) && waitReg);
      if (rdStrobe) rdataReg <= {24'h000000, rdByte};
    end
  end

  // software registers; read-only and reserved writes fall through
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syncReg       <= `SCTBM_RST_SYNC_CTL;
      fastReg       <= 1'b0;
      dataPortReg   <= `SCTBM_RST_DATA_PORT;
      assertDataReg <= 1'b0;
      irqMaskReg    <= `SCTBM_RST_IRQ;
      irqStatReg    <= `SCTBM_RST_IRQ;
    end else begin
      if (wrSync) syncReg <= wrByte;
      if (wrConfig) fastReg <= wrByte[`SCTBM_BIT_FAST];
      if (wrDataPort) dataPortReg <= wrByte;
      if (wrCommand && wrByte == `SCTBM_CMD_ASSERT_DATA) assertDataReg <= 1'b1;
      else if (wrCommand && wrByte == `SCTBM_CMD_DEASSERT_DATA) assertDataReg <= 1'b0;
      if (wrIrqMask) irqMaskReg <= wrByte[1:0];
      irqStatReg <= irqStatNext;  // events win over the clear
    end
  end

  // byte counter and transfer bookkeeping
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      byteCountReg <= `SCTBM_RST_XFER_COUNT;
      toRequestReg <= 5'h00;
      xferOnReg    <= 1'b0;
    end else begin
      if (wrCount && !xferOnReg) begin
        byteCountReg <= wrByte[4:0];
      end else if (pushByte && byteCountReg != 5'h00) begin
        byteCountReg <= byteCountReg - 5'h01;
      end
      if (wrCommand && wrByte == `SCTBM_CMD_START_XFER) begin
        xferOnReg    <= 1'b1;
        toRequestReg <= byteCountReg;
      end else if ((wrCommand && wrByte == `SCTBM_CMD_STOP_XFER) || xferDone) begin
        xferOnReg    <= 1'b0;
        toRequestReg <= 5'h00;
      end else if (reqIssue) begin
        toRequestReg <= toRequestReg - 5'h01;
      end
    end
  end

  // handshake state, cycle position and unanswered requests
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stateReg    <= sctbm_pkg::ST_IDLE;
      cycCntReg   <= 5'h00;
      outstandReg <= 5'h00;
      ackPrevReg  <= 1'b0;
      fullPrevReg <= 1'b0;
    end else begin
      stateReg    <= stateNext;
      cycCntReg   <= reqIssue ? 5'h00 : cycCntReg + 5'h01;
      ackPrevReg  <= ackSense;
      fullPrevReg <= fullFlag;
      if (!xferOnReg) outstandReg <= 5'h00;
      else if (reqIssue && !pushByte) outstandReg <= outstandReg + 5'h01;
      else if (pushByte && !reqIssue) outstandReg <= outstandReg - 5'h01;
    end
  end

  // pin and interrupt flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dataOutReg <= 8'hff;
      dataOeReg  <= 1'b1;
      reqReg     <= 1'b1;
      irqReg     <= 1'b0;
    end else begin
      dataOutReg <= ~dataPortReg;
      dataOeReg  <= !assertDataReg;
      reqReg     <= !(stateNext == sctbm_pkg::ST_REQ_HI);
      irqReg     <= |(irqStatNext & irqMaskReg);
    end
  end

  assign avs_waitrequest = waitReg;
  assign avs_readdata    = rdataReg;
  assign scsiDataOutN    = dataOutReg;
  assign scsiDataOeN     = dataOeReg;
  assign reqLineN        = reqReg;
  assign irq             = irqReg;

  // built-in fifo: filled from the bus on acknowledge, drained by cpu reads
  sctbm_fifo u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pushValid (pushByte),
    .pushData  (dataSense),
    .pushReady (pushReady),
    .popValid  (popValid),
    .popReady  (rdFifo),
    .popData   (popData),
    .fillCount (fillCount),
    .emptyFlag (emptyFlag),
    .fullFlag  (fullFlag)
  );

  // spacing between synchronous request starts
  logic [5:0] sinceIssueReg;  // cycles since last request start, saturating
  always_ff @(posedge clk) begin
    if (sys_rst) sinceIssueReg <= 6'h3f;
    else if (reqIssue) sinceIssueReg <= 6'h01;
    else if (sinceIssueReg != 6'h3f) sinceIssueReg <= sinceIssueReg + 6'h01;
  end

  // checks
  a_monitor_live: assert property (@(posedge clk) disable iff (sys_rst)
    rdStrobe && aligned && regIdx == `SCTBM_IDX_LINE_MONITOR |=> avs_readdata[7:0] == ~$past(scsiCtlN))
    else $error("monitor read not the live lines");
  a_empty_flag: assert property (@(posedge clk) disable iff (sys_rst)
    rdStrobe && aligned && regIdx == `SCTBM_IDX_FIFO_STATUS
      |=> avs_readdata[`SCTBM_BIT_EMPTY] == ($past(fillCount) == 4'h0))
    else $error("empty flag wrong");
  a_full_flag: assert property (@(posedge clk) disable iff (sys_rst)
    rdStrobe && aligned && regIdx == `SCTBM_IDX_FIFO_STATUS
      |=> avs_readdata[`SCTBM_BIT_FULL] == ($past(fillCount) == 4'hf))
    else $error("full flag wrong");
  a_fill_count: assert property (@(posedge clk) disable iff (sys_rst)
    pushByte && pushReady && !rdFifo |=> fillCount == $past(fillCount) + 4'h1)
    else $error("fill count missed a push");
  a_data_drive: assert property (@(posedge clk) disable iff (sys_rst)
    assertDataReg && $stable(dataPortReg) |=> !scsiDataOeN && scsiDataOutN == ~$past(dataPortReg))
    else $error("data port not driven");
  a_data_sample: assert property (@(posedge clk) disable iff (sys_rst)
    rdStrobe && aligned && regIdx == `SCTBM_IDX_BUS_DATA_PORT |=> avs_readdata[7:0] == ~$past(scsiDataInN))
    else $error("data read not the bus");
  a_count_upper: assert property (@(posedge clk) disable iff (sys_rst)
    rdStrobe && aligned && regIdx == `SCTBM_IDX_XFER_COUNT |=> avs_readdata[7:5] == 3'b000)
    else $error("counter upper bits set");
  a_sync_readback: assert property (@(posedge clk) disable iff (sys_rst)
    wrSync |=> syncReg == $past(avs_writedata[7:0]))
    else $error("sync control lost write");
  a_cycle_length: assert property (@(posedge clk) disable iff (sys_rst)
    reqIssue && syncMode && $stable(syncReg) && $stable(fastReg) |-> sinceIssueReg >= {1'b0, cycleLen})
    else $error("synchronous cycle too short");
  a_async_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !syncMode && stateReg == sctbm_pkg::ST_REQ_HI && !ackSense && $stable(syncReg) |=> !reqLineN)
    else $error("request dropped before acknowledge");
  a_offset_limit: assert property (@(posedge clk) disable iff (sys_rst)
    syncMode && $stable(syncReg) |-> outstandReg <= {1'b0, offsetField})
    else $error("too many unanswered requests");
  a_counter_zero: assert property (@(posedge clk) disable iff (sys_rst)
    rdStrobe && aligned && regIdx == `SCTBM_IDX_MODULE_STATUS
      |=> avs_readdata[`SCTBM_BIT_CNT_ZERO] == ($past(byteCountReg) == 5'h00))
    else $error("counter-zero flag wrong");
  a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
    rdStrobe && (regIdx == `SCTBM_IDX_RSVD_52 || regIdx == `SCTBM_IDX_RSVD_56 || regIdx == `SCTBM_IDX_RSVD_5C)
      |=> avs_readdata == 32'h0000_0000)
    else $error("reserved read not zero");
  a_reserved_rest: assert property (@(posedge clk) disable iff (sys_rst)
    rdStrobe && (regIdx == `SCTBM_IDX_RSVD_53 || regIdx == `SCTBM_IDX_RSVD_59 || regIdx == `SCTBM_IDX_RSVD_5A)
      |=> avs_readdata == 32'h0000_0000)
    else $error("other reserved read not zero");
  a_release_pins: assert property (@(posedge clk) disable iff (sys_rst)
    !assertDataReg |=> scsiDataOeN)
    else $error("data lines driven after deassert");
endmodule : sctbm_regs

// ---- tb/sctbm_initiator.sv ----
// initiator model: answers request pulses with a delayed acknowledge and a byte
`timescale 1ns/1ns
module sctbm_initiator (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       reqLineN,
  input  wire logic [7:0] scsiDataOutN,
  input  wire logic       scsiDataOeN,
  input  wire logic [7:0] ctlPos,
  input  wire logic [3:0] ackDly,
  output logic      [7:0] scsiCtlN,
  output logic      [7:0] scsiDataInN
);
  logic [16:0] reqHist; // request history, newest in bit 0
  logic [7:0]  seqByte; // byte handed over on the next acknowledge
  logic        ackOn;   // acknowledge asserted
  assign ackOn = reqHist[ackDly];
  // request history and byte sequence; next byte once acknowledge drops
  always @(posedge clk) begin
    if (sys_rst) begin
      reqHist <= '0;
      seqByte <= 8'h00;
    end else begin
      reqHist <= {reqHist[15:0], ~reqLineN};
      if (!ackOn && reqHist[ackDly + 5'd1]) seqByte <= seqByte + 8'h01;
    end
  end
  // wired bus with pull-ups: released lines read high
  assign scsiDataInN = (ackOn ? ~seqByte : 8'hff) & (scsiDataOeN ? 8'hff : scsiDataOutN);
  assign scsiCtlN    = ~(ctlPos | {5'h00, ~reqLineN, ackOn, 1'b0});
endmodule : sctbm_initiator

// ---- tb/tb_top.sv ----
// self-checking bench for the bus monitor register bank
`timescale 1ns/1ns
`include "sctbm_cfg.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_top;
  logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest, scsiDataOeN, reqLineN, irq;
  logic [8:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [7:0]  scsiCtlN, scsiDataInN, scsiDataOutN, ctlPos, v, expSeq;
  logic [3:0]  ackDly;
  logic        reqPrev, ackPrev; // previous pin levels
  int n_errors, checks, cyc, lastFall, gap, reqFalls, ackFalls, maxOut;
  sctbm_regs dut_u (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_byteenable(4'h1),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scsiCtlN(scsiCtlN), .scsiDataInN(scsiDataInN),
    .scsiDataOutN(scsiDataOutN), .scsiDataOeN(scsiDataOeN), .reqLineN(reqLineN), .irq(irq));
  sctbm_initiator far_u (.clk(clk), .sys_rst(sys_rst), .reqLineN(reqLineN), .scsiDataOutN(scsiDataOutN),
    .scsiDataOeN(scsiDataOeN), .ctlPos(ctlPos), .ackDly(ackDly), .scsiCtlN(scsiCtlN), .scsiDataInN(scsiDataInN));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // request spacing and unanswered request tracking, plus hang guard
  always @(posedge clk) begin
    cyc++;
    if (reqPrev && !reqLineN) begin
      reqFalls++;
      gap = cyc - lastFall;
      lastFall = cyc;
    end
    if (ackPrev && !scsiCtlN[1]) ackFalls++;
    if (reqFalls - ackFalls > maxOut) maxOut = reqFalls - ackFalls;
    reqPrev = reqLineN;
    ackPrev = scsiCtlN[1];
    if (cyc > 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // avalon write: hold until waitrequest sampled low
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : wr
  // avalon read: data taken at the edge with waitrequest low
  task automatic rd(input logic [6:0] idx, output logic [7:0] d);
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
  endtask : rd
  // start a transfer and poll until no longer in progress
  task automatic xfer(input logic [7:0] n);
    int k;
    wr(`SCTBM_IDX_XFER_COUNT, n);
    maxOut = 0;
    reqFalls = 0;
    ackFalls = 0;
    wr(`SCTBM_IDX_MODULE_STATUS, `SCTBM_CMD_START_XFER);
    k = 0;
    do begin
      rd(`SCTBM_IDX_MODULE_STATUS, v);
      k++;
    end while (v[0] !== 1'b0 && k < 300);
    `CHK("xfer done", 1'b0, v[0])
  endtask : xfer
  // pop bytes, checking sequence and fill status before each pop
  task automatic drain(input int n);
    logic [3:0] f;
    for (int k = n; k > 0; k--) begin
      f = 4'(k);
      rd(`SCTBM_IDX_FIFO_STATUS, v);
      `CHK("fifo status", {1'b0, 2'b00, k == 15, f}, v)
      rd(`SCTBM_IDX_FIFO_READ, v);
      `CHK("fifo byte", expSeq, v)
      expSeq++;
    end
    rd(`SCTBM_IDX_FIFO_STATUS, v);
    `CHK("fifo empty", 8'h80, v)
  endtask : drain
  task automatic t_reset;
    rd(`SCTBM_IDX_FIFO_STATUS, v);
    `CHK("fifo status rst", 8'h80, v)
    rd(`SCTBM_IDX_XFER_COUNT, v);
    `CHK("count rst", 8'h00, v)
    rd(`SCTBM_IDX_SYNC_CTL, v);
    `CHK("sync rst", 8'h00, v)
    rd(`SCTBM_IDX_MODULE_STATUS, v);
    `CHK("count zero", 1'b1, v[2])
  endtask : t_reset
  task automatic t_monitor;
    for (int i = 0; i < 8; i++) begin
      ctlPos <= 8'h01 << i;
      rd(`SCTBM_IDX_LINE_MONITOR, v);
      `CHK("monitor", 8'h01 << i, v)
    end
    ctlPos <= 8'h00;
  endtask : t_monitor
  task automatic t_regs;
    logic [6:0] rsv [6] = '{7'h52, 7'h53, 7'h56, 7'h59, 7'h5a, 7'h5c};
    wr(`SCTBM_IDX_SYNC_CTL, 8'ha5);
    wr(`SCTBM_IDX_LINE_MONITOR, 8'hff);
    wr(`SCTBM_IDX_FIFO_STATUS, 8'hff);
    foreach (rsv[i]) begin
      wr(rsv[i], 8'hff);
      rd(rsv[i], v);
      `CHK("reserved", 8'h00, v)
    end
    rd(`SCTBM_IDX_FIFO_STATUS, v);
    `CHK("ro status", 8'h80, v)
    rd(`SCTBM_IDX_SYNC_CTL, v);
    `CHK("sync readback", 8'ha5, v)
    wr(`SCTBM_IDX_XFER_COUNT, 8'hf0);
    rd(`SCTBM_IDX_XFER_COUNT, v);
    `CHK("count width", 8'h10, v)
    wr(`SCTBM_IDX_SYNC_CTL, 8'h00);
  endtask : t_regs
  task automatic t_data;
    wr(`SCTBM_IDX_BUS_DATA_PORT, 8'h3c);
    wr(`SCTBM_IDX_MODULE_STATUS, `SCTBM_CMD_ASSERT_DATA);
    repeat (2) @(posedge clk);
    #1 `CHK("drive pins", 9'h0c3, {scsiDataOeN, scsiDataOutN})
    rd(`SCTBM_IDX_BUS_DATA_PORT, v);
    `CHK("data sense", 8'h3c, v)
    wr(`SCTBM_IDX_MODULE_STATUS, `SCTBM_CMD_DEASSERT_DATA);
    repeat (2) @(posedge clk);
    #1 `CHK("released", 1'b1, scsiDataOeN)
    rd(`SCTBM_IDX_BUS_DATA_PORT, v);
    `CHK("idle sense", 8'h00, v)
  endtask : t_data
  task automatic t_async;
    ackDly <= 4'h3;
    wr(`SCTBM_IDX_IRQ_MASK, 8'h00);
    xfer(8'h0f);
    rd(`SCTBM_IDX_FIFO_STATUS, v);
    `CHK("fifo full", 8'h1f, v)
    rd(`SCTBM_IDX_MODULE_STATUS, v);
    `CHK("zero with data", 1'b1, v[2])
    `CHK("async one out", 1, maxOut)
    `CHK("irq masked", 1'b0, irq)
    rd(`SCTBM_IDX_IRQ_STATUS, v);
    `CHK("irq status", 8'h03, v)
    wr(`SCTBM_IDX_IRQ_MASK, 8'h03);
    repeat (2) @(posedge clk);
    `CHK("irq raised", 1'b1, irq)
    drain(15);
    wr(`SCTBM_IDX_IRQ_STATUS, 8'h03);
    repeat (2) @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
  endtask : t_async
  task automatic t_sync(input logic fast, input int expGap);
    ackDly <= 4'h1;
    wr(`SCTBM_IDX_SECOND_CONFIG, {fast, 7'h00});
    rd(`SCTBM_IDX_SECOND_CONFIG, v);
    `CHK("fast select", {fast, 7'h00}, v)
    wr(`SCTBM_IDX_SYNC_CTL, 8'h3f);
    xfer(8'h04);
    `CHK("cycle length", expGap, gap)
    drain(4);
  endtask : t_sync
  task automatic t_offset;
    ackDly <= 4'hc;
    wr(`SCTBM_IDX_SYNC_CTL, 8'h31);
    xfer(8'h03);
    `CHK("offset limit", 1, maxOut)
    drain(3);
  endtask : t_offset
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  initial begin
    {sys_rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 43'h0};
    {ctlPos, ackDly, expSeq, reqPrev, ackPrev} = {8'h00, 4'h1, 8'h00, 2'b11};
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_monitor();
    t_regs();
    t_data();
    t_async();
    t_sync(1'b1, 7);
    t_sync(1'b0, 11);
    t_offset();
    report_and_stop();
  end
endmodule : tb_top
